// >>> move_or_rotate_exec_unit.sv
// Top of the move/rotate execution unit with its AXI4-Lite register slave
//
// Overview of operation
// RULE_01 - Literal load fills work register, flags untouched
// RULE_02 - OR work with file, update zero
// RULE_03 - OR result to work or file by dest
// RULE_04 - Store work into file, flags untouched
// RULE_05 - File move to work or back by dest
// RULE_06 - File move always updates zero flag
// RULE_07 - Rotate left through carry, only carry changes
// RULE_08 - Rotate result to work or file by dest
// RULE_09 - Interrupt return loads PC, sets irq enable
// RULE_10 - Idle changes nothing, PC advances
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module move_or_rotate_exec_unit
   import exec_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i
);

   // ==========================================================
   // State
   logic [DATA_W-1:0] file_mem [FILE_DEPTH];
   logic [DATA_W-1:0] work_r, work_nxt;
   logic              zero_r, zero_nxt;
   logic              carry_r, carry_nxt;
   logic              gie_r, gie_nxt;
   logic [PC_W-1:0]   pc_r, pc_nxt;
   logic [PC_W-1:0]   stack_top_r, stack_top_nxt;
   logic [31:0]       instr_r, instr_nxt;
   logic [ADDR_W-1:0] faddr_r, faddr_nxt;
   logic              fwr_en;
   logic [ADDR_W-1:0] fwr_addr;
   logic [DATA_W-1:0] fwr_data;

   logic              aw_got_r, aw_got_nxt;
   logic              w_got_r, w_got_nxt;
   logic [7:0]        awaddr_r, awaddr_nxt;
   logic [31:0]       wdata_r, wdata_nxt;
   logic [3:0]        wstrb_r, wstrb_nxt;
   logic              bvalid_r, bvalid_nxt;
   logic [1:0]        bresp_r, bresp_nxt;
   logic              rvalid_r, rvalid_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   logic [1:0]        rresp_r, rresp_nxt;

   // ==========================================================
   // Decode helpers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            m[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // ==========================================================
   // Instruction execution
   logic [3:0]        opc;
   logic              dest;
   logic [ADDR_W-1:0] iaddr;
   logic [DATA_W-1:0] alu_res;
   logic              alu_zu, alu_cu, alu_c;
   logic              wr_fire, exec_go;

   assign opc   = instr_r[OPC_LSB +: 4];
   assign dest  = instr_r[DEST_BIT];
   assign iaddr = instr_r[ADDR_W-1:0];

   exec_alu u_alu (
      .opc_i       (opc),
      .work_i      (work_r),
      .file_i      (file_mem[iaddr]),
      .lit_i       (instr_r[DATA_W-1:0]),
      .carry_i     (carry_r),
      .result_o    (alu_res),
      .zero_upd_o  (alu_zu),
      .carry_upd_o (alu_cu),
      .carry_o     (alu_c)
   );

   assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
   // Writing bit 0 of the control word launches the held instruction
   assign exec_go = wr_fire && (awaddr_r == CTRL_OFF) && wstrb_r[0] && wdata_r[0];

   always_comb begin
      work_nxt      = work_r;
      zero_nxt      = zero_r;
      carry_nxt     = carry_r;
      gie_nxt       = gie_r;
      pc_nxt        = pc_r;
      stack_top_nxt = stack_top_r;
      instr_nxt     = instr_r;
      faddr_nxt     = faddr_r;
      fwr_en        = 1'b0;
      fwr_addr      = iaddr;
      fwr_data      = alu_res;
      if (exec_go) begin
         pc_nxt = pc_r + 13'h0001; // RULE_10
         if (alu_zu) begin
            zero_nxt = (alu_res == 8'h00); // RULE_02 RULE_06
         end
         if (alu_cu) begin
            carry_nxt = alu_c; // RULE_07
         end
         case (opc)
            load_literal_op: begin
               work_nxt = alu_res; // RULE_01
            end
            store_work_op: begin
               fwr_en = 1'b1; // RULE_04
            end
            or_with_file_op, file_move_op, rotate_left_carry_op: begin
               if (dest) begin
                  fwr_en = 1'b1; // RULE_03 RULE_05 RULE_08
               end else begin
                  work_nxt = alu_res; // RULE_03 RULE_05 RULE_08
               end
            end
            interrupt_return_op: begin
               pc_nxt  = stack_top_r; // RULE_09
               gie_nxt = 1'b1; // RULE_09
            end
            default: begin
               pc_nxt = pc_r + 13'h0001; // RULE_10
            end
         endcase
      end else if (wr_fire) begin
         case (awaddr_r)
            INSTR_OFF: instr_nxt = merge(instr_r, wdata_r, wstrb_r);
            WORK_OFF: begin
               if (wstrb_r[0]) work_nxt = wdata_r[DATA_W-1:0];
            end
            STATUS_OFF: begin
               if (wstrb_r[0]) begin
                  zero_nxt  = wdata_r[ZERO_BIT];
                  carry_nxt = wdata_r[CARRY_BIT];
                  gie_nxt   = wdata_r[GIE_BIT];
               end
            end
            PC_OFF: pc_nxt = PC_W'(merge(32'(pc_r), wdata_r, wstrb_r));
            STACK_OFF: stack_top_nxt = PC_W'(merge(32'(stack_top_r), wdata_r, wstrb_r));
            FADDR_OFF: begin
               if (wstrb_r[0]) faddr_nxt = wdata_r[ADDR_W-1:0];
            end
            FDATA_OFF: begin
               fwr_en   = wstrb_r[0];
               fwr_addr = faddr_r;
               fwr_data = wdata_r[DATA_W-1:0];
            end
            default: begin
               fwr_en = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         work_r      <= WORK_RST;
         zero_r      <= 1'b0;
         carry_r     <= 1'b0;
         gie_r       <= 1'b0;
         pc_r        <= PC_RST;
         stack_top_r <= PC_RST;
         instr_r     <= 32'h0000_0000;
         faddr_r     <= 7'h00;
      end else begin
         work_r      <= work_nxt;
         zero_r      <= zero_nxt;
         carry_r     <= carry_nxt;
         gie_r       <= gie_nxt;
         pc_r        <= pc_nxt;
         stack_top_r <= stack_top_nxt;
         instr_r     <= instr_nxt;
         faddr_r     <= faddr_nxt;
      end
   end

   // File array has no reset; contents are undefined until written
   always_ff @(posedge clk_i) begin
      if (fwr_en) begin
         file_mem[fwr_addr] <= fwr_data;
      end
   end

   // ==========================================================
   // AXI4-Lite write channel
   function automatic logic known_addr(input logic [7:0] a);
      return a inside {CTRL_OFF, INSTR_OFF, WORK_OFF, STATUS_OFF, PC_OFF, STACK_OFF, FADDR_OFF, FDATA_OFF};
   endfunction

   always_comb begin
      aw_got_nxt = aw_got_r;
      w_got_nxt  = w_got_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt  = wdata_r;
      wstrb_nxt  = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt  = bresp_r;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_got_nxt = 1'b1;
         awaddr_nxt = {s_axi_awaddr_i[7:2], 2'b00};
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_got_nxt = 1'b1;
         wdata_nxt = s_axi_wdata_i;
         wstrb_nxt = s_axi_wstrb_i;
      end
      if (wr_fire) begin
         aw_got_nxt = 1'b0;
         w_got_nxt  = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt  = known_addr(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready_i) begin
         bvalid_nxt = 1'b0;
      end
   end

   // Ready only while the slot is empty and no response waits, so one write is under way at a time
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         aw_got_r        <= 1'b0;
         w_got_r         <= 1'b0;
         awaddr_r        <= 8'h00;
         wdata_r         <= 32'h0000_0000;
         wstrb_r         <= 4'h0;
         bvalid_r        <= 1'b0;
         bresp_r         <= RESP_OKAY;
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o  <= 1'b0;
      end else begin
         aw_got_r        <= aw_got_nxt;
         w_got_r         <= w_got_nxt;
         awaddr_r        <= awaddr_nxt;
         wdata_r         <= wdata_nxt;
         wstrb_r         <= wstrb_nxt;
         bvalid_r        <= bvalid_nxt;
         bresp_r         <= bresp_nxt;
         s_axi_awready_o <= !aw_got_nxt && !bvalid_nxt;
         s_axi_wready_o  <= !w_got_nxt && !bvalid_nxt;
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = RESP_OKAY;
         case ({s_axi_araddr_i[7:2], 2'b00})
            CTRL_OFF:   rdata_nxt = 32'h0000_0000;
            INSTR_OFF:  rdata_nxt = instr_r;
            WORK_OFF:   rdata_nxt = {24'h000000, work_r};
            STATUS_OFF: rdata_nxt = {29'h0, gie_r, carry_r, zero_r};
            PC_OFF:     rdata_nxt = {19'h0, pc_r};
            STACK_OFF:  rdata_nxt = {19'h0, stack_top_r};
            FADDR_OFF:  rdata_nxt = {25'h0, faddr_r};
            FDATA_OFF:  rdata_nxt = {24'h000000, file_mem[faddr_r]};
            default: begin
               rdata_nxt = 32'h0000_0000;
               rresp_nxt = RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready_i) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rvalid_r        <= 1'b0;
         rdata_r         <= 32'h0000_0000;
         rresp_r         <= RESP_OKAY;
         s_axi_arready_o <= 1'b0;
      end else begin
         rvalid_r        <= rvalid_nxt;
         rdata_r         <= rdata_nxt;
         rresp_r         <= rresp_nxt;
         s_axi_arready_o <= !rvalid_nxt;
      end
   end

   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o  = bresp_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o  = rdata_r;
   assign s_axi_rresp_o  = rresp_r;

endmodule

// >>> exec_pkg.sv
// Package of constants and types for the move/rotate execution unit
package exec_pkg;

   // ==========================================================
   // Data widths
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int PC_W   = 13;
   localparam int FILE_DEPTH = 128;

   // ==========================================================
   // AXI4-Lite register offsets (byte addresses)
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] INSTR_OFF  = 8'h04;
   localparam logic [7:0] WORK_OFF   = 8'h08;
   localparam logic [7:0] STATUS_OFF = 8'h0C;
   localparam logic [7:0] PC_OFF     = 8'h10;
   localparam logic [7:0] STACK_OFF  = 8'h14;
   localparam logic [7:0] FADDR_OFF  = 8'h18;
   localparam logic [7:0] FDATA_OFF  = 8'h1C;

   // ==========================================================
   // Instruction word fields
   localparam int OPC_LSB  = 16;
   localparam int DEST_BIT = 8;

   // ==========================================================
   // Status field positions
   localparam int ZERO_BIT  = 0;
   localparam int CARRY_BIT = 1;
   localparam int GIE_BIT   = 2;

   // ==========================================================
   // Reset values
   localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
   localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;

   // ==========================================================
   // Operation codes
   typedef enum logic [3:0] {
      idle_op              = 4'h0,
      load_literal_op      = 4'h1,
      or_with_file_op      = 4'h2,
      store_work_op        = 4'h3,
      file_move_op         = 4'h4,
      interrupt_return_op  = 4'h5,
      rotate_left_carry_op = 4'h6
   } opcode_e;

   // ==========================================================
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> exec_alu.sv
// Combinational result and flag logic for one instruction
`timescale 1ns/1ps
module exec_alu
   import exec_pkg::*;
(
   input  wire logic [3:0]        opc_i,
   input  wire logic [DATA_W-1:0] work_i,
   input  wire logic [DATA_W-1:0] file_i,
   input  wire logic [DATA_W-1:0] lit_i,
   input  wire logic              carry_i,
   output logic      [DATA_W-1:0] result_o,
   output logic                   zero_upd_o,
   output logic                   carry_upd_o,
   output logic                   carry_o
);

   always_comb begin
      result_o    = file_i;
      zero_upd_o  = 1'b0;
      carry_upd_o = 1'b0;
      carry_o     = carry_i;
      case (opc_i)
         load_literal_op: begin
            result_o = lit_i; // RULE_01
         end
         or_with_file_op: begin
            result_o   = work_i | file_i; // RULE_02
            zero_upd_o = 1'b1;
         end
         store_work_op: begin
            result_o = work_i; // RULE_04
         end
         file_move_op: begin
            result_o   = file_i; // RULE_05
            zero_upd_o = 1'b1; // RULE_06
         end
         rotate_left_carry_op: begin
            result_o    = {file_i[DATA_W-2:0], carry_i}; // RULE_07
            carry_o     = file_i[DATA_W-1];
            carry_upd_o = 1'b1;
         end
         default: begin
            result_o = file_i;
         end
      endcase
   end

endmodule

// >>> move_or_rotate_exec_unit_checker.sv
// Bus handshake checker for the move/rotate execution unit
`timescale 1ns/1ps
module move_or_rotate_exec_unit_checker
   import exec_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic [7:0]  s_axi_awaddr_i,
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0]  s_axi_wstrb_i,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic [7:0]  s_axi_araddr_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0]  s_axi_rresp_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i
);
   // ==========================================================
   // Handshake properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   AST_BRESP_HOLD:
      assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped or changed before bready");
   AST_RDATA_HOLD:
      assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)
                       && $stable(s_axi_rresp_o))
      else $error("read data dropped or changed before rready");
   AST_AR_BLOCKED:
      assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read address accepted while read data pending");
   AST_W_BLOCKED:
      assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write accepted while response pending");
   AST_READ_LATENCY:
      assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read data not one cycle after address");
   AST_WRITE_LATENCY:
      assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
                       |-> ##[1:2] s_axi_bvalid_o)
      else $error("write response late");
   AST_B_RELEASE:
      assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o ##[0:1] s_axi_awready_o)
      else $error("write response not retired or readies not back");
   AST_R_RELEASE:
      assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
      else $error("read data not retired");
   AST_R_CAUSE:
      assert property ($rose(s_axi_rvalid_o) |-> $past(s_axi_arvalid_i) && $past(s_axi_arready_o))
      else $error("read data without an accepted address");
   AST_RESP_CODE:
      assert property (s_axi_bvalid_o |-> s_axi_bresp_o == RESP_OKAY || s_axi_bresp_o == RESP_SLVERR)
      else $error("illegal write response code");
endmodule

bind move_or_rotate_exec_unit move_or_rotate_exec_unit_checker chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i));

// >>> tb_move_or_rotate_exec_unit.sv
// Self-checking testbench for the move/rotate execution unit
`timescale 1ns/1ps
module tb_move_or_rotate_exec_unit;
   import exec_pkg::*;
   // ==========================================================
   // Signals
   logic        clk_i, sys_rst_i, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd_v;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, wr_resp, rd_resp;
   logic [12:0] pc_exp;
   int          mismatches, compares;

   move_or_rotate_exec_unit dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // ==========================================================
   // Reporting
   task automatic summarize;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // ==========================================================
   // Bus master; st holds the response ready low for st cycles
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input int st = 0);
      int n, w;
      n = 0;
      w = 0;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= (st == 0);
      while (n < 100) begin
         @(posedge clk_i);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1 && bready) break;
         if (bvalid === 1'b1) begin
            w++;
            if (w >= st) bready <= 1'b1;
         end
      end
      if (n >= 100) begin
         mismatches++;
         summarize();
      end
      wr_resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input int st = 0);
      int n, w;
      n = 0;
      w = 0;
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= (st == 0);
      while (n < 100) begin
         @(posedge clk_i);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1 && rready) break;
         if (rvalid === 1'b1) begin
            w++;
            if (w >= st) rready <= 1'b1;
         end
      end
      if (n >= 100) begin
         mismatches++;
         summarize();
      end
      rd_v = rdata;
      rd_resp = rresp;
      rready <= 1'b0;
   endtask

   // ==========================================================
   // Instruction helpers
   function automatic logic [31:0] ins(input opcode_e o, input logic d, input logic [7:0] k);
      return {12'h000, o, 7'h00, d, k};
   endfunction

   task automatic ex(input opcode_e o, input logic d, input logic [7:0] k);
      wr(INSTR_OFF, ins(o, d, k));
      wr(CTRL_OFF, 32'h1);
      pc_exp++;
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(nm, rd_v, e);
   endtask

   task automatic setf(input logic [7:0] a, input logic [7:0] v);
      wr(FADDR_OFF, {24'h0, a});
      wr(FDATA_OFF, {24'h0, v});
   endtask

   task automatic getf(input logic [7:0] a);
      wr(FADDR_OFF, {24'h0, a});
      rd(FDATA_OFF);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      rchk("work", WORK_OFF, 32'h0);
      rchk("status", STATUS_OFF, 32'h0);
      rchk("pc", PC_OFF, 32'h0);
      rd(CTRL_OFF, 2);
      chk("ctrl", rd_v, 32'h0);
      rd(8'h40, 3);
      chk("rresp", {30'h0, rd_resp}, {30'h0, RESP_SLVERR});
      wr(8'h40, 32'hFFFFFFFF, 3);
      chk("bresp", {30'h0, wr_resp}, {30'h0, RESP_SLVERR});
   endtask

   task automatic t_literal;
      wr(STATUS_OFF, 32'h2);
      ex(load_literal_op, 1'b0, 8'hFF);
      rchk("work", WORK_OFF, 32'hFF);
      ex(load_literal_op, 1'b0, 8'h00);
      rchk("work", WORK_OFF, 32'h0);
      rchk("status", STATUS_OFF, 32'h2);
   endtask

   task automatic t_or;
      wr(STATUS_OFF, 32'h0);
      setf(8'h7F, 8'h00);
      ex(load_literal_op, 1'b0, 8'h00);
      ex(or_with_file_op, 1'b0, 8'h7F);
      rchk("status", STATUS_OFF, 32'h1);
      setf(8'h7F, 8'hA0);
      ex(load_literal_op, 1'b0, 8'h5A);
      ex(or_with_file_op, 1'b1, 8'h7F);
      getf(8'h7F);
      chk("file", rd_v, 32'hFA);
      rchk("work", WORK_OFF, 32'h5A);
      rchk("status", STATUS_OFF, 32'h0);
   endtask

   task automatic t_store;
      wr(STATUS_OFF, 32'h3);
      ex(load_literal_op, 1'b0, 8'h3C);
      ex(store_work_op, 1'b0, 8'h00);
      getf(8'h00);
      chk("file", rd_v, 32'h3C);
      rchk("status", STATUS_OFF, 32'h3);
   endtask

   task automatic t_move;
      wr(STATUS_OFF, 32'h0);
      setf(8'h05, 8'h00);
      ex(load_literal_op, 1'b0, 8'h77);
      ex(file_move_op, 1'b1, 8'h05);
      rchk("status", STATUS_OFF, 32'h1);
      rchk("work", WORK_OFF, 32'h77);
      getf(8'h05);
      chk("file", rd_v, 32'h0);
      setf(8'h06, 8'h81);
      ex(file_move_op, 1'b0, 8'h06);
      rchk("work", WORK_OFF, 32'h81);
      rchk("status", STATUS_OFF, 32'h0);
   endtask

   task automatic t_rotate;
      wr(STATUS_OFF, 32'h0);
      setf(8'h09, 8'h80);
      ex(rotate_left_carry_op, 1'b1, 8'h09);
      getf(8'h09);
      chk("file", rd_v, 32'h0);
      rchk("status", STATUS_OFF, 32'h2);
      setf(8'h0A, 8'h40);
      ex(load_literal_op, 1'b0, 8'h11);
      ex(rotate_left_carry_op, 1'b0, 8'h0A);
      rchk("work", WORK_OFF, 32'h81);
      rchk("status", STATUS_OFF, 32'h0);
      getf(8'h0A);
      chk("file", rd_v, 32'h40);
   endtask

   task automatic t_return;
      wr(STACK_OFF, 32'h1ABC);
      wr(STATUS_OFF, 32'h3);
      ex(load_literal_op, 1'b0, 8'h66);
      ex(idle_op, 1'b0, 8'h0A);
      rchk("pc", PC_OFF, {19'h0, pc_exp});
      rchk("work", WORK_OFF, 32'h66);
      rchk("status", STATUS_OFF, 32'h3);
      getf(8'h0A);
      chk("file", rd_v, 32'h40);
      ex(interrupt_return_op, 1'b0, 8'h00);
      rchk("pc", PC_OFF, 32'h1ABC);
      rchk("status", STATUS_OFF, 32'h7);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      sys_rst_i = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      pc_exp = 13'h0000;
      mismatches = 0;
      compares = 0;
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_literal();
      t_or();
      t_store();
      t_move();
      t_rotate();
      t_return();
      summarize();
   end
endmodule
